// [design/tcr_consts.svh]
/*
 Constants of the rule store: update-control fields, timing, widths,
 type-group bit counts and default rule placement.
 Assumes it is included by its bare name from the design files.
*/
`ifndef TCR_CONSTS_SVH
`define TCR_CONSTS_SVH

`define TCR_CMD_LSB 0
`define TCR_CMD_MSB 2
`define TCR_ADDR_LSB 3
`define TCR_ADDR_MSB 18
`define TCR_WIPE_BIT 31
`define TCR_CMD_WRITE 3'h4
`define TCR_CMD_INIT 3'h5
`define TCR_CLK_MHZ 50
`define TCR_WRITE_NS 40
`define TCR_ENT_W 52
`define TCR_ENT_WORDS 4'h2
`define TCR_RW_ENT_W 51
`define TCR_RW_ACT_W 489
`define TCR_RW_ADDRS 16'h1000
`define TCR_EACL_BLOCK_ADDRS 16'h3000

`define TCR_TG_E1 5'h01
`define TCR_TG_E3 5'h03
`define TCR_TG_E7 5'h07
`define TCR_TG_E13 5'h0D
`define TCR_TG_ACL_ACT 3'h4

`define TCR_RULE_STEP 16'h000C
`define TCR_IACL_DEF0 16'h8BB0
`define TCR_IACL_DEF1 16'h8EF8
`define TCR_IACL_DEF0_N 7'h46
`define TCR_RW_DEF_N 7'h46
`define TCR_EACL_DEF0 16'h2FC4
`define TCR_EACL_DEF1 16'h336C
`define TCR_EACL_DEF0_N 7'h49
`define TCR_TWO_LOOKUPS 2'h2

`endif

// [design/tcr_pkg.sv]
/*
 Types of the rule store: table selector, rule sizes, cache word
 selector and the writer state.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package tcr_pkg;

   typedef enum logic [1:0] {
      TBL_ROUTE = 2'h0,
      TBL_IACL = 2'h1,
      TBL_EACL = 2'h2,
      TBL_RW = 2'h3
   } tcr_table_t;

   typedef enum logic [2:0] {
      SZ_X1 = 3'h0,
      SZ_X2 = 3'h1,
      SZ_X3 = 3'h2,
      SZ_X6 = 3'h3,
      SZ_X12 = 3'h4
   } tcr_size_t;

   typedef enum logic [1:0] {
      SEL_ENTRY = 2'h0,
      SEL_MASK = 2'h1,
      SEL_ACTION = 2'h2
   } tcr_sel_t;

   typedef enum logic {
      ST_IDLE = 1'b0,
      ST_WRITE = 1'b1
   } tcr_state_t;

endpackage

// [design/tcr_look_if.sv]
/*
 Carrier between the rule store and its match engine: stored rules,
 one lookup request and the registered lookup answer.
 Assumes both ends run on the same clock.
*/
`include "tcr_consts.svh"

interface tcr_look_if
   import tcr_pkg::*;
#(
   parameter int DEPTH = 16,
   parameter int ACT_W = `TCR_RW_ACT_W
);
   localparam int IW = $clog2(DEPTH);

   logic [DEPTH-1:0] live;
   tcr_table_t [DEPTH-1:0] own;
   logic [DEPTH-1:0][`TCR_ENT_W-1:0] ent;
   logic [DEPTH-1:0][`TCR_ENT_W-1:0] msk;
   logic [DEPTH-1:0][ACT_W-1:0] act;
   logic req_valid;
   tcr_table_t req_table;
   logic [1:0] req_lookup;
   logic [6:0] req_rule;
   logic req_blocks;
   logic [`TCR_ENT_W-1:0] req_key;
   logic res_valid;
   logic res_hit;
   logic res_default;
   logic res_miss;
   logic [IW-1:0] res_idx;
   logic [15:0] res_addr;
   logic [ACT_W-1:0] res_action;

   modport store (
      output live, own, ent, msk, act,
      output req_valid, req_table, req_lookup, req_rule, req_blocks, req_key,
      input res_valid, res_hit, res_default, res_miss, res_idx, res_addr, res_action
   );

   modport engine (
      input live, own, ent, msk, act,
      input req_valid, req_table, req_lookup, req_rule, req_blocks, req_key,
      output res_valid, res_hit, res_default, res_miss, res_idx, res_addr, res_action
   );
endinterface

// [design/tcr_lookup.sv]
/*
 Match engine: searches the stored rules for a key and, in parallel,
 picks the table's default rule; the answer is registered.
 Assumes the request is held valid for one cycle and is on mclk.
*/
`include "tcr_consts.svh"

module tcr_lookup
   import tcr_pkg::*;
#(
   parameter int DEPTH = 16,
   parameter int ACT_W = `TCR_RW_ACT_W
) (
   input wire logic mclk,
   input wire logic rst,
   tcr_look_if.engine lk
);
   localparam int IW = $clog2(DEPTH);

   typedef struct packed {
      logic valid;
      logic hit;
      logic dflt;
      logic miss;
      logic [IW-1:0] idx;
      logic [15:0] addr;
      logic [ACT_W-1:0] act;
   } tcr_res_t;

   tcr_res_t s;
   tcr_res_t next_s;
   logic found;
   logic [IW-1:0] fidx;
   logic lk_ok;
   logic dflt_ok;
   logic [15:0] daddr;

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      found = 1'b0;
      fidx = '0;
      // lowest address wins, so scan downward
      for (int i = DEPTH - 1; i >= 0; i--) begin
         if (lk.live[i] && lk.own[i] == lk.req_table &&
             ((lk.req_key ^ lk.ent[i]) & ~lk.msk[i]) == '0) begin
            found = 1'b1;
            fidx = IW'(i);
         end
      end
      lk_ok = 1'b1;
      dflt_ok = 1'b0;
      daddr = 16'h0000;
      case (lk.req_table)
         TBL_ROUTE: begin
            lk_ok = lk.req_lookup < `TCR_TWO_LOOKUPS;
            dflt_ok = 1'b0;
         end
         TBL_IACL: begin
            if (lk.req_lookup == 2'h0) begin
               dflt_ok = lk.req_rule < `TCR_IACL_DEF0_N;
               daddr = 16'(`TCR_IACL_DEF0 + 16'(lk.req_rule) * `TCR_RULE_STEP);
            end else begin
               dflt_ok = 1'b1;
               daddr = 16'(`TCR_IACL_DEF1 + 16'(lk.req_lookup - 2'h1) * `TCR_RULE_STEP);
            end
         end
         TBL_RW: begin
            lk_ok = lk.req_lookup == 2'h0;
            dflt_ok = lk.req_rule < `TCR_RW_DEF_N;
            daddr = 16'(`TCR_RW_ADDRS + 16'(lk.req_rule));
         end
         TBL_EACL: begin
            lk_ok = lk.req_lookup < `TCR_TWO_LOOKUPS;
            if (lk.req_lookup == 2'h0) begin
               dflt_ok = lk.req_rule < `TCR_EACL_DEF0_N;
               daddr = 16'(`TCR_EACL_DEF0 + 16'(lk.req_rule) * `TCR_RULE_STEP);
            end else begin
               dflt_ok = 1'b1;
               daddr = `TCR_EACL_DEF1;
            end
         end
         default: lk_ok = 1'b0;
      endcase
      next_s.valid = lk.req_valid;
      // shared tables with no blocks assigned can never match
      next_s.hit = lk.req_valid && lk_ok && found && (lk.req_blocks || lk.req_table == TBL_RW);
      next_s.dflt = lk.req_valid && lk_ok && !next_s.hit && dflt_ok;
      next_s.miss = lk.req_valid && !next_s.hit && !next_s.dflt;
      next_s.idx = fidx;
      next_s.addr = next_s.hit ? 16'(fidx) : (next_s.dflt ? daddr : 16'h0000);
      next_s.act = next_s.hit ? lk.act[fidx] : '0;
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   assign lk.res_valid = s.valid;
   assign lk.res_hit = s.hit;
   assign lk.res_default = s.dflt;
   assign lk.res_miss = s.miss;
   assign lk.res_idx = s.idx;
   assign lk.res_addr = s.addr;
   assign lk.res_action = s.act;

endmodule // tcr_lookup

// [design/tcr_rule_store.sv]
/*
 Rule store of the lookup tables: software fills a cache of entry,
 mask and action words, then commands a copy of the cache into rule
 memory through the update-control word; lookups search that memory.
 Assumes all inputs come from logic on mclk; software keeps the
 placement and ordering duties of its own.
*/
`include "tcr_consts.svh"

module tcr_rule_store
   import tcr_pkg::*;
#(
   parameter int DEPTH = 16,
   parameter int ACT_W = `TCR_RW_ACT_W
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic cache_wr_valid,
   input wire tcr_sel_t cache_wr_sel,
   input wire logic [3:0] cache_wr_word,
   input wire logic [31:0] cache_wr_data,
   input wire logic ctrl_wr_valid,
   input wire logic [31:0] ctrl_wr_data,
   input wire tcr_table_t target_table,
   output logic update_pending,
   output logic cmd_ignored,
   input wire logic look_valid,
   input wire tcr_table_t look_table,
   input wire logic [1:0] look_lookup,
   input wire logic [6:0] look_rule,
   input wire logic look_blocks,
   input wire logic [`TCR_ENT_W-1:0] look_key,
   output logic res_valid,
   output logic res_hit,
   output logic res_default,
   output logic res_miss,
   output logic [15:0] res_addr,
   output logic [ACT_W-1:0] res_action,
   input wire logic [$clog2(DEPTH)-1:0] hit_count_addr,
   output logic hit_count,
   input wire tcr_table_t tg_table,
   input wire tcr_size_t tg_size,
   output logic [4:0] tg_entry_bits,
   output logic [2:0] tg_action_bits,
   output logic tg_legal
);
   localparam int IW = $clog2(DEPTH);
   localparam int AW_N = (ACT_W + 31) / 32;
   localparam int WRITE_CYC_I = (`TCR_WRITE_NS * `TCR_CLK_MHZ + 999) / 1000;
   localparam logic [3:0] WRITE_CYC = 4'((WRITE_CYC_I < 1) ? 1 : WRITE_CYC_I);
   localparam logic [3:0] ACT_WORDS = 4'(AW_N - 1);

   typedef struct packed {
      tcr_state_t st;
      logic [3:0] cnt;
      logic [15:0] addr;
      tcr_table_t tbl;
      logic init;
      logic pending;
      logic ignored;
      logic [1:0][31:0] c_ent;
      logic [1:0][31:0] c_msk;
      logic [AW_N-1:0][31:0] c_act;
      logic c_cnt;
      tcr_table_t [DEPTH-1:0] own;
      logic [DEPTH-1:0][`TCR_ENT_W-1:0] ent;
      logic [DEPTH-1:0][`TCR_ENT_W-1:0] msk;
      logic [DEPTH-1:0][ACT_W-1:0] act;
      logic [DEPTH-1:0] cntr;
      logic hit_cnt;
      logic [4:0] tg_e;
      logic [2:0] tg_a;
      logic tg_ok;
   } tcr_state_all_t;

   tcr_state_all_t s;
   tcr_state_all_t next_s;
   tcr_look_if #(.DEPTH(DEPTH), .ACT_W(ACT_W)) lk();
   logic [2:0] ctrl_cmd;
   logic [`TCR_ENT_W-1:0] cache_entry;
   logic [`TCR_ENT_W-1:0] cache_mask;
   logic [AW_N*32-1:0] cache_action;
   logic [IW-1:0] slot;
   logic slot_ok;

   ////////////////////////////////////////////////////////////////////////////
   // stored rules and the lookup request go to the match engine
   assign lk.own = s.own;
   assign lk.ent = s.ent;
   assign lk.msk = s.msk;
   assign lk.act = s.act;
   assign lk.req_valid = look_valid;
   assign lk.req_table = look_table;
   assign lk.req_lookup = look_lookup;
   assign lk.req_rule = look_rule;
   assign lk.req_blocks = look_blocks;
   assign lk.req_key = look_key;

   // an all-zero entry and mask is match-off, which the wipe leaves behind
   generate
      for (genvar g = 0; g < DEPTH; g++) begin : g_live
         assign lk.live[g] = (|s.ent[g]) || (|s.msk[g]);
      end
   endgenerate

   tcr_lookup #(.DEPTH(DEPTH), .ACT_W(ACT_W)) u_lookup (
      .mclk(mclk),
      .rst(rst),
      .lk(lk)
   );

   ////////////////////////////////////////////////////////////////////////////
   assign ctrl_cmd = ctrl_wr_data[`TCR_CMD_MSB:`TCR_CMD_LSB];
   assign cache_entry = {s.c_ent[1][`TCR_ENT_W-33:0], s.c_ent[0]};
   assign cache_mask = {s.c_msk[1][`TCR_ENT_W-33:0], s.c_msk[0]};
   assign cache_action = s.c_act;
   assign slot = s.addr[IW-1:0];
   // only the low DEPTH addresses have storage; other writes are dropped
   assign slot_ok = s.addr < 16'(DEPTH);

   always_comb begin
      next_s = s;
      next_s.ignored = 1'b0;

      // cache fill from software
      if (cache_wr_valid) begin
         if (s.pending) begin
            next_s.ignored = 1'b1;
         end else begin
            case (cache_wr_sel)
               SEL_ENTRY: begin
                  if (cache_wr_word < `TCR_ENT_WORDS) begin
                     next_s.c_ent[cache_wr_word[0]] = cache_wr_data;
                  end
               end
               SEL_MASK: begin
                  if (cache_wr_word < `TCR_ENT_WORDS) begin
                     next_s.c_msk[cache_wr_word[0]] = cache_wr_data;
                  end
               end
               SEL_ACTION: begin
                  if (cache_wr_word <= ACT_WORDS) begin
                     next_s.c_act[cache_wr_word] = cache_wr_data;
                  end
               end
               default: ;
            endcase
         end
      end

      // update-control write: wipe first, then the command sees the wiped cache
      if (ctrl_wr_valid) begin
         if (s.pending) begin
            next_s.ignored = 1'b1;
         end else begin
            if (ctrl_wr_data[`TCR_WIPE_BIT]) begin
               next_s.c_ent = '0;
               next_s.c_msk = '0;
               next_s.c_act = '0;
               next_s.c_cnt = 1'b0;
            end
            if (ctrl_cmd == `TCR_CMD_WRITE || ctrl_cmd == `TCR_CMD_INIT) begin
               next_s.st = ST_WRITE;
               next_s.pending = 1'b1;
               next_s.cnt = WRITE_CYC - 4'h1;
               next_s.addr = ctrl_wr_data[`TCR_ADDR_MSB:`TCR_ADDR_LSB];
               next_s.tbl = target_table;
               next_s.init = ctrl_cmd == `TCR_CMD_INIT;
            end
         end
      end

      // a hit sets the saturating one-bit counter of the rule's address
      if (lk.res_valid && lk.res_hit) begin
         next_s.cntr[lk.res_idx] = 1'b1;
      end

      case (s.st)
         ST_IDLE: ;
         ST_WRITE: begin
            if (s.cnt == 4'h0) begin
               if (slot_ok) begin
                  next_s.own[slot] = s.tbl;
                  if (s.init) begin
                     // initialize deletes the rule at this address
                     next_s.ent[slot] = '0;
                     next_s.msk[slot] = '0;
                     next_s.act[slot] = '0;
                     next_s.cntr[slot] = 1'b0;
                  end else begin
                     next_s.ent[slot] = cache_entry;
                     next_s.msk[slot] = cache_mask;
                     next_s.act[slot] = cache_action[ACT_W-1:0];
                     next_s.cntr[slot] = s.c_cnt;
                     if (s.tbl == TBL_RW) begin
                        // rewrite entries are narrower; the spare bit never blocks a match
                        next_s.ent[slot][`TCR_RW_ENT_W] = 1'b0;
                        next_s.msk[slot][`TCR_RW_ENT_W] = 1'b1;
                     end
                  end
               end
               // pending drops on the same edge the rule lands in memory
               next_s.pending = 1'b0;
               next_s.st = ST_IDLE;
            end else begin
               next_s.cnt = s.cnt - 4'h1;
            end
         end
         default: begin
            next_s.st = ST_IDLE;
            next_s.pending = 1'b0;
         end
      endcase

      next_s.hit_cnt = s.cntr[hit_count_addr];

      // type-group widths per table and rule size
      next_s.tg_e = 5'h00;
      next_s.tg_a = 3'h0;
      next_s.tg_ok = 1'b1;
      case (tg_table)
         TBL_ROUTE: begin
            next_s.tg_a = 3'h0;
            case (tg_size)
               SZ_X1: next_s.tg_e = `TCR_TG_E1;
               SZ_X2: next_s.tg_e = `TCR_TG_E3;
               SZ_X3: next_s.tg_e = `TCR_TG_E7;
               SZ_X6: next_s.tg_e = `TCR_TG_E13;
               default: next_s.tg_ok = 1'b0;
            endcase
         end
         TBL_IACL, TBL_EACL: begin
            next_s.tg_a = `TCR_TG_ACL_ACT;
            case (tg_size)
               SZ_X3: next_s.tg_e = `TCR_TG_E1;
               SZ_X6: next_s.tg_e = `TCR_TG_E3;
               SZ_X12: next_s.tg_e = `TCR_TG_E7;
               default: next_s.tg_ok = 1'b0;
            endcase
         end
         TBL_RW: begin
            // single size only, so no type-group field at all
            next_s.tg_ok = tg_size == SZ_X1;
         end
         default: next_s.tg_ok = 1'b0;
      endcase
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   assign update_pending = s.pending;
   assign cmd_ignored = s.ignored;
   assign hit_count = s.hit_cnt;
   assign tg_entry_bits = s.tg_e;
   assign tg_action_bits = s.tg_a;
   assign tg_legal = s.tg_ok;
   // lookup answers are registered inside the match engine
   assign res_valid = lk.res_valid;
   assign res_hit = lk.res_hit;
   assign res_default = lk.res_default;
   assign res_miss = lk.res_miss;
   assign res_addr = lk.res_addr;
   assign res_action = lk.res_action;

endmodule // tcr_rule_store

// [bench/tcr_rule_store_properties.sv]
/*
 Checker of the rule store ports: command timing, refusals, lookup
 answers and type-group sizes.
 Assumes it is bound to tcr_rule_store, one clock mclk, rst active high.
*/
`include "tcr_consts.svh"

module tcr_rule_store_properties
   import tcr_pkg::*;
#(
   parameter int DEPTH = 16,
   parameter int ACT_W = `TCR_RW_ACT_W
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic cache_wr_valid,
   input wire tcr_sel_t cache_wr_sel,
   input wire logic [3:0] cache_wr_word,
   input wire logic [31:0] cache_wr_data,
   input wire logic ctrl_wr_valid,
   input wire logic [31:0] ctrl_wr_data,
   input wire tcr_table_t target_table,
   input wire logic update_pending,
   input wire logic cmd_ignored,
   input wire logic look_valid,
   input wire tcr_table_t look_table,
   input wire logic [1:0] look_lookup,
   input wire logic [6:0] look_rule,
   input wire logic look_blocks,
   input wire logic [`TCR_ENT_W-1:0] look_key,
   input wire logic res_valid,
   input wire logic res_hit,
   input wire logic res_default,
   input wire logic res_miss,
   input wire logic [15:0] res_addr,
   input wire logic [ACT_W-1:0] res_action,
   input wire logic [$clog2(DEPTH)-1:0] hit_count_addr,
   input wire logic hit_count,
   input wire tcr_table_t tg_table,
   input wire tcr_size_t tg_size,
   input wire logic [4:0] tg_entry_bits,
   input wire logic [2:0] tg_action_bits,
   input wire logic tg_legal
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);

   ////////////////////////////////////////////////////////////////////////////
   property p_pend_len;
      $rose(update_pending) |=> update_pending ##1 !update_pending;
   endproperty
   a_pend_len: assert property (p_pend_len) else $error("pending length wrong");
   property p_cmd_take;
      ctrl_wr_valid && !update_pending && ctrl_wr_data[2:0] == `TCR_CMD_WRITE |=> update_pending;
   endproperty
   a_cmd_take: assert property (p_cmd_take) else $error("write command not taken");
   property p_refuse;
      (cache_wr_valid || ctrl_wr_valid) && update_pending |=> cmd_ignored;
   endproperty
   a_refuse: assert property (p_refuse) else $error("refusal not flagged");
   property p_quiet;
      !update_pending |=> !cmd_ignored;
   endproperty
   a_quiet: assert property (p_quiet) else $error("spurious refusal");
   property p_res_lat;
      1'b1 |=> res_valid == $past(look_valid);
   endproperty
   a_res_lat: assert property (p_res_lat) else $error("lookup answer latency");
   property p_one;
      res_valid |-> $onehot({res_hit, res_default, res_miss});
   endproperty
   a_one: assert property (p_one) else $error("answer kind not unique");
   property p_route_miss;
      look_valid && look_table == TBL_ROUTE && !look_blocks |=> res_miss && res_addr == 16'h0000;
   endproperty
   a_route_miss: assert property (p_route_miss) else $error("route without blocks");
   property p_iacl_def;
      look_valid && look_table == TBL_IACL && !look_blocks && look_lookup == 2'h2
         |=> res_default && res_addr == 16'h8F04;
   endproperty
   a_iacl_def: assert property (p_iacl_def) else $error("ingress default wrong");
   property p_eacl_def;
      look_valid && look_table == TBL_EACL && !look_blocks && look_lookup == 2'h0
         && look_rule < 7'h49 |=> res_default && res_addr == 16'h2FC4 + 16'h000C * $past(look_rule);
   endproperty
   a_eacl_def: assert property (p_eacl_def) else $error("egress default wrong");
   property p_tg_route;
      tg_table == TBL_ROUTE && tg_size == SZ_X6 |=> tg_entry_bits == 5'h0D && tg_legal;
   endproperty
   a_tg_route: assert property (p_tg_route) else $error("route type-group size");
endmodule // tcr_rule_store_properties

bind tcr_rule_store tcr_rule_store_properties #(.DEPTH(DEPTH), .ACT_W(ACT_W)) u_chk (.*);

// [bench/test_tcr_rule_store.sv]
/*
 Testbench of the rule store: rule writes, refusals, wipe, defaults,
 hit bit and type-group sizes.
 Assumes design and checker are compiled first; inputs change at negedge.
*/
`include "tcr_consts.svh"

`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin n_fail++; \
   $display("[FAIL] %s expected %h seen %h", nm, ex, got); end end

module test_tcr_rule_store
   import tcr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int DEPTH = 16;
   localparam int ACT_W = `TCR_RW_ACT_W;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic cache_wr_valid = 1'b0;
   tcr_sel_t cache_wr_sel = SEL_ENTRY;
   logic [3:0] cache_wr_word = 4'h0;
   logic [31:0] cache_wr_data = 32'h0;
   logic ctrl_wr_valid = 1'b0;
   logic [31:0] ctrl_wr_data = 32'h0;
   tcr_table_t target_table = TBL_ROUTE;
   logic update_pending, cmd_ignored, res_valid, res_hit, res_default, res_miss, hit_count;
   logic look_valid = 1'b0;
   tcr_table_t look_table = TBL_ROUTE;
   logic [1:0] look_lookup = 2'h0;
   logic [6:0] look_rule = 7'h00;
   logic look_blocks = 1'b0;
   logic [`TCR_ENT_W-1:0] look_key = '0;
   logic [15:0] res_addr;
   logic [ACT_W-1:0] res_action, exp_act;
   logic [$clog2(DEPTH)-1:0] hit_count_addr = '0;
   tcr_table_t tg_table = TBL_ROUTE;
   tcr_size_t tg_size = SZ_X1;
   logic [4:0] tg_entry_bits;
   logic [2:0] tg_action_bits;
   logic tg_legal;
   int n_fail = 0;
   int num_checks = 0;
   int cyc = 0;

   tcr_rule_store #(.DEPTH(DEPTH), .ACT_W(ACT_W)) u_tcr_rule_store (.*);

   initial forever #10 mclk = ~mclk;

   // the whole run is some 60 cycles; the ceiling leaves ample margin
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 3000) begin
         n_fail++;
         conclude();
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic conclude();
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // strobes of cw and look stay up between calls; ctl drops them
   task automatic cw(input tcr_sel_t s, input logic [3:0] w, input logic [31:0] d);
      cache_wr_valid = 1'b1;
      cache_wr_sel = s;
      cache_wr_word = w;
      cache_wr_data = d;
      @(negedge mclk);
   endtask

   task automatic ctl(input logic [31:0] d);
      cache_wr_valid = 1'b0;
      look_valid = 1'b0;
      ctrl_wr_valid = 1'b1;
      ctrl_wr_data = d;
      target_table = TBL_ROUTE;
      @(negedge mclk);
      ctrl_wr_valid = 1'b0;
   endtask

   task automatic look(input tcr_table_t t, input logic [1:0] l, input logic [6:0] r,
                       input logic b, input logic [`TCR_ENT_W-1:0] k);
      look_valid = 1'b1;
      look_table = t;
      look_lookup = l;
      look_rule = r;
      look_blocks = b;
      look_key = k;
      @(negedge mclk);
   endtask

   task automatic ld(input tcr_table_t t, input logic [1:0] l, input logic [6:0] r,
                     input logic b, input logic [15:0] a, input logic df);
      look(t, l, r, b, '0);
      `CHK("res_default", df, res_default)
      `CHK("res_miss", !df, res_miss)
      `CHK("res_addr", a, res_addr)
   endtask

   task automatic tgc(input tcr_table_t t, input tcr_size_t s, input logic [4:0] eb,
                      input logic [2:0] ab, input logic lg);
      tg_table = t;
      tg_size = s;
      @(negedge mclk);
      `CHK("tg_legal", lg, tg_legal)
      if (lg) begin
         `CHK("tg_entry_bits", eb, tg_entry_bits)
         `CHK("tg_action_bits", ab, tg_action_bits)
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      `CHK("update_pending", 1'b0, update_pending)
      `CHK("res_valid", 1'b0, res_valid)
      `CHK("hit_count", 1'b0, hit_count)
      $display("t_reset done");
   endtask

   task automatic t_write();
      cw(SEL_ENTRY, 4'h0, 32'h0000_00A5);
      cw(SEL_MASK, 4'h1, 32'h000F_FFFF);
      cw(SEL_ACTION, 4'h0, 32'h1234_5678);
      cw(SEL_ACTION, 4'hF, 32'h0000_00EF);
      ctl(32'h0000_002C);
      `CHK("update_pending", 1'b1, update_pending)
      cw(SEL_ACTION, 4'h0, 32'hFFFF_FFFF);
      `CHK("cmd_ignored", 1'b1, cmd_ignored)
      `CHK("update_pending", 1'b1, update_pending)
      cache_wr_valid = 1'b0;
      @(negedge mclk);
      `CHK("update_pending", 1'b0, update_pending)
      exp_act = '0;
      exp_act[31:0] = 32'h1234_5678;
      exp_act[ACT_W-1:480] = 9'h0EF;
      look(TBL_ROUTE, 2'h0, 7'h00, 1'b1, 52'h1_2345_0000_00A5);
      `CHK("res_hit", 1'b1, res_hit)
      `CHK("res_addr", 16'h0005, res_addr)
      `CHK("res_action", exp_act, res_action)
      look_valid = 1'b0;
      hit_count_addr = 4'h5;
      repeat (2) @(negedge mclk);
      `CHK("hit_count", 1'b1, hit_count)
      hit_count_addr = 4'h6;
      @(negedge mclk);
      `CHK("hit_count", 1'b0, hit_count)
      $display("t_write done");
   endtask

   // two-address rule at 6..7, highest offset first; offset 0 left match-off
   task automatic t_wipe();
      ctl(32'h8000_0000);
      cw(SEL_ENTRY, 4'h0, 32'h0000_003C);
      ctl(32'h0000_003C);
      repeat (2) @(negedge mclk);
      ctl(32'h8000_0034);
      repeat (2) @(negedge mclk);
      look(TBL_ROUTE, 2'h0, 7'h00, 1'b1, 52'h0_0000_0000_003C);
      `CHK("res_addr", 16'h0007, res_addr)
      `CHK("res_action", {ACT_W{1'b0}}, res_action)
      look(TBL_ROUTE, 2'h0, 7'h00, 1'b1, 52'h1_0000_0000_003C);
      `CHK("res_miss", 1'b1, res_miss)
      look(TBL_ROUTE, 2'h0, 7'h00, 1'b1, 52'h0);
      `CHK("res_miss", 1'b1, res_miss)
      look(TBL_ROUTE, 2'h0, 7'h00, 1'b0, 52'h1_2345_0000_00A5);
      `CHK("res_miss", 1'b1, res_miss)
      look_valid = 1'b0;
      hit_count_addr = 4'h7;
      @(negedge mclk);
      `CHK("hit_count", 1'b1, hit_count)
      ctl(32'h0000_003D);
      repeat (2) @(negedge mclk);
      look(TBL_ROUTE, 2'h0, 7'h00, 1'b1, 52'h0_0000_0000_003C);
      `CHK("res_miss", 1'b1, res_miss)
      `CHK("hit_count", 1'b0, hit_count)
      look_valid = 1'b0;
      $display("t_wipe done");
   endtask

   task automatic t_defaults();
      ld(TBL_IACL, 2'h0, 7'h00, 1'b1, 16'h8BB0, 1'b1);
      ld(TBL_IACL, 2'h0, 7'h45, 1'b0, 16'h8BB0 + 16'h000C * 16'h0045, 1'b1);
      ld(TBL_IACL, 2'h0, 7'h46, 1'b0, 16'h0000, 1'b0);
      ld(TBL_IACL, 2'h1, 7'h00, 1'b0, 16'h8EF8, 1'b1);
      ld(TBL_IACL, 2'h2, 7'h00, 1'b0, 16'h8F04, 1'b1);
      ld(TBL_IACL, 2'h3, 7'h00, 1'b0, 16'h8F10, 1'b1);
      ld(TBL_RW, 2'h0, 7'h45, 1'b1, 16'h1045, 1'b1);
      ld(TBL_RW, 2'h0, 7'h46, 1'b1, 16'h0000, 1'b0);
      ld(TBL_EACL, 2'h0, 7'h48, 1'b0, 16'h2FC4 + 16'h000C * 16'h0048, 1'b1);
      ld(TBL_EACL, 2'h0, 7'h49, 1'b0, 16'h0000, 1'b0);
      ld(TBL_EACL, 2'h1, 7'h00, 1'b1, 16'h336C, 1'b1);
      ld(TBL_EACL, 2'h2, 7'h00, 1'b1, 16'h0000, 1'b0);
      ld(TBL_ROUTE, 2'h0, 7'h00, 1'b1, 16'h0000, 1'b0);
      look_valid = 1'b0;
      $display("t_defaults done");
   endtask

   task automatic t_tg();
      tgc(TBL_ROUTE, SZ_X1, 5'h01, 3'h0, 1'b1);
      tgc(TBL_ROUTE, SZ_X2, 5'h03, 3'h0, 1'b1);
      tgc(TBL_ROUTE, SZ_X3, 5'h07, 3'h0, 1'b1);
      tgc(TBL_ROUTE, SZ_X6, 5'h0D, 3'h0, 1'b1);
      tgc(TBL_ROUTE, SZ_X12, 5'h00, 3'h0, 1'b0);
      tgc(TBL_IACL, SZ_X1, 5'h00, 3'h0, 1'b0);
      tgc(TBL_IACL, SZ_X3, 5'h01, 3'h4, 1'b1);
      tgc(TBL_IACL, SZ_X6, 5'h03, 3'h4, 1'b1);
      tgc(TBL_IACL, SZ_X12, 5'h07, 3'h4, 1'b1);
      tgc(TBL_EACL, SZ_X3, 5'h01, 3'h4, 1'b1);
      tgc(TBL_EACL, SZ_X6, 5'h03, 3'h4, 1'b1);
      tgc(TBL_EACL, SZ_X12, 5'h07, 3'h4, 1'b1);
      tgc(TBL_RW, SZ_X1, 5'h00, 3'h0, 1'b1);
      tgc(TBL_RW, SZ_X3, 5'h00, 3'h0, 1'b0);
      $display("t_tg done");
   endtask

   initial begin
      repeat (6) @(negedge mclk);
      rst = 1'b0;
      @(negedge mclk);
      t_reset();
      t_write();
      t_wipe();
      t_defaults();
      t_tg();
      conclude();
   end
endmodule // test_tcr_rule_store
